// file: mci_busy_counter.sv
`timescale 1ns/1ns
`default_nettype none
`include "mci_consts.svh"
module mci_busy_counter (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       start,
  output logic            busy,
  output logic [1:0]      remain
);
  logic [1:0] count_q;
  logic [1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (start) begin
      count_d = `MCI_BUSY_CYCLES;
    end else if (count_q != `MCI_BUSY_ZERO) begin
      count_d = count_q - `MCI_BUSY_ONE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= `MCI_BUSY_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  assign busy   = (count_q != `MCI_BUSY_ZERO);
  assign remain = count_q;

  chk_busy_two_cycles: assert property (@(posedge clock) disable iff (!reset_n)
    start |=> busy ##1 busy ##1 (!busy || $past(start)))
    else $error("busy did not last two cycles");
endmodule : mci_busy_counter
`default_nettype wire

// file: mci_consts.svh
`ifndef MCI_CONSTS_SVH
`define MCI_CONSTS_SVH
`define MCI_BUSY_CYCLES   2'h2
`define MCI_BUSY_ZERO     2'h0
`define MCI_BUSY_ONE      2'h1
`endif

// file: mci_interlock.sv
`timescale 1ns/1ns
`default_nettype none
`include "mci_consts.svh"
module mci_interlock (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire mci_pkg::mci_stage_t ex_stage,
  input  wire logic               fetch_req,
  input  wire logic               cached_variant,
  input  wire logic               cache_enable,
  output logic                    hold_front,
  output logic                    ma_active,
  output logic                    ma_fetch_split,
  output logic                    mult_access,
  output logic                    mult_busy
);
  // ---------------------------------------------------------------
  // Access stage tracking
  // ---------------------------------------------------------------
  mci_pkg::mci_stage_t ma_q;
  mci_pkg::mci_stage_t ma_d;
  mci_pkg::mci_state_t state_q;
  mci_pkg::mci_state_t state_d;
  logic                mul_done;
  logic [1:0]          remain;
  logic                split_q;
  logic                split_d;

  function automatic logic needs_mult(input mci_pkg::mci_op_t op);
    needs_mult = (op == mci_pkg::MCI_OP_STS_REG) ||
                 (op == mci_pkg::MCI_OP_STS_MEM) ||
                 (op == mci_pkg::MCI_OP_LDS_REG) ||
                 (op == mci_pkg::MCI_OP_MULW);
  endfunction : needs_mult

  function automatic logic may_stall(input mci_pkg::mci_op_t op,
                                     input logic cv, input logic ce);
    case (op)
      mci_pkg::MCI_OP_STS_REG: may_stall = 1'b1;
      mci_pkg::MCI_OP_LDS_REG: may_stall = 1'b1;
      mci_pkg::MCI_OP_STS_MEM: may_stall = !(cv && ce);
      mci_pkg::MCI_OP_MULW:    may_stall = 1'b1;
      default:                 may_stall = 1'b0;
    endcase
  endfunction : may_stall

  logic ma_stall;
  logic ma_fetch;

  // Word multiply ends its access stage: busy counter starts
  assign mul_done = ma_q.valid && (ma_q.op == mci_pkg::MCI_OP_MULW) && !hold_front;

  mci_busy_counter u_busy (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (mul_done),
    .busy    (mult_busy),
    .remain  (remain)
  );

  always_comb begin
    ma_stall = ma_q.valid && needs_mult(ma_q.op) &&
               may_stall(ma_q.op, cached_variant, cache_enable) && mult_busy;
    ma_fetch = ma_q.valid && fetch_req &&
               (ma_q.op == mci_pkg::MCI_OP_STS_REG ||
                ma_q.op == mci_pkg::MCI_OP_STS_MEM ||
                ma_q.op == mci_pkg::MCI_OP_LDS_REG ||
                ma_q.op == mci_pkg::MCI_OP_MULW);
  end

  // ---------------------------------------------------------------
  // Slot control
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    split_d = 1'b0;
    case (state_q)
      mci_pkg::MCI_ST_IDLE: begin
        if (ma_stall) begin
          state_d = mci_pkg::MCI_ST_STRETCH;
        end else if (ma_fetch) begin
          state_d = mci_pkg::MCI_ST_SPLIT;
          split_d = 1'b1;
        end
      end
      mci_pkg::MCI_ST_STRETCH: begin
        if (!ma_stall) begin
          state_d = ma_fetch ? mci_pkg::MCI_ST_SPLIT : mci_pkg::MCI_ST_IDLE;
          split_d = ma_fetch;
        end
      end
      mci_pkg::MCI_ST_SPLIT: begin
        state_d = mci_pkg::MCI_ST_IDLE;
      end
      default: state_d = mci_pkg::MCI_ST_IDLE;
    endcase
  end

  // Fetch gets the first half of a split slot, access the second
  assign hold_front = ma_stall || (ma_fetch && state_q != mci_pkg::MCI_ST_SPLIT);

  always_comb begin
    ma_d = ma_q;
    if (!hold_front) begin
      ma_d = ex_stage;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ma_q    <= '0;
      state_q <= mci_pkg::MCI_ST_IDLE;
      split_q <= 1'b0;
    end else begin
      ma_q    <= ma_d;
      state_q <= state_d;
      split_q <= split_d;
    end
  end

  assign ma_active      = ma_q.valid;
  assign ma_fetch_split = split_q;
  assign mult_access    = ma_q.valid && needs_mult(ma_q.op) && !hold_front;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_dmul_no_wait: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_q.valid && ma_q.op == mci_pkg::MCI_OP_DMUL && !fetch_req) |-> !hold_front)
    else $error("double multiply waited on busy");
  chk_sts_stretch: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_q.valid && ma_q.op == mci_pkg::MCI_OP_STS_REG && mult_busy) |-> hold_front)
    else $error("store access not stretched");
  chk_lds_stretch: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_q.valid && ma_q.op == mci_pkg::MCI_OP_LDS_REG && mult_busy) |-> hold_front)
    else $error("load access not stretched");
  chk_stretch_ends: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_stall && !fetch_req) |-> ##[1:3] !hold_front)
    else $error("stretch did not end");
  chk_cached_store: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_q.valid && ma_q.op == mci_pkg::MCI_OP_STS_MEM && cached_variant &&
     cache_enable && !fetch_req) |-> !hold_front)
    else $error("cached store stalled");
  chk_uncached_store: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_q.valid && ma_q.op == mci_pkg::MCI_OP_STS_MEM && !cached_variant && mult_busy)
    |-> hold_front)
    else $error("uncached store not stalled");
  chk_store_split: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == mci_pkg::MCI_ST_IDLE && !ma_stall && ma_fetch &&
     ma_q.op != mci_pkg::MCI_OP_LDS_REG) |=> split_q)
    else $error("store slot not split");
  chk_load_split: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == mci_pkg::MCI_ST_IDLE && !ma_stall && ma_fetch &&
     ma_q.op == mci_pkg::MCI_OP_LDS_REG) |=> split_q ##1 !split_q)
    else $error("load slot not split");
  chk_lds_access: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_q.valid && ma_q.op == mci_pkg::MCI_OP_LDS_REG && !hold_front) |-> mult_access)
    else $error("load missing multiplier access");
  chk_sts_access: assert property (@(posedge clock) disable iff (!reset_n)
    (ma_q.valid && ma_q.op == mci_pkg::MCI_OP_STS_REG && !hold_front) |-> mult_access)
    else $error("store missing multiplier access");
  chk_remain_bound: assert property (@(posedge clock) disable iff (!reset_n)
    mult_busy |-> (remain != `MCI_BUSY_ZERO) && (remain <= `MCI_BUSY_CYCLES))
    else $error("busy count out of range");

  cov_sts_stretch: cover property (@(posedge clock) disable iff (!reset_n)
    state_q == mci_pkg::MCI_ST_STRETCH ##1 state_q == mci_pkg::MCI_ST_SPLIT);
  cov_lds_stretch: cover property (@(posedge clock) disable iff (!reset_n)
    ma_stall && ma_q.op == mci_pkg::MCI_OP_LDS_REG);
  cov_cached_pass: cover property (@(posedge clock) disable iff (!reset_n)
    ma_q.op == mci_pkg::MCI_OP_STS_MEM && mult_busy && !hold_front);
  cov_idle_split: cover property (@(posedge clock) disable iff (!reset_n)
    state_q == mci_pkg::MCI_ST_IDLE && ma_fetch && !ma_stall);
endmodule : mci_interlock
`default_nettype wire

// file: mci_pkg.sv
package mci_pkg;
  typedef enum logic [2:0] {
    MCI_OP_OTHER   = 3'h0,
    MCI_OP_MULW    = 3'h1,
    MCI_OP_DMUL    = 3'h2,
    MCI_OP_STS_REG = 3'h3,
    MCI_OP_STS_MEM = 3'h4,
    MCI_OP_LDS_REG = 3'h5
  } mci_op_t;

  typedef struct packed {
    logic    valid;
    mci_op_t op;
  } mci_stage_t;

  typedef enum logic [1:0] {
    MCI_ST_IDLE    = 2'h0,
    MCI_ST_STRETCH = 2'h1,
    MCI_ST_SPLIT   = 2'h2
  } mci_state_t;
endpackage : mci_pkg

// file: mci_testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                clock;
  logic                reset_n;
  mci_pkg::mci_stage_t ex_stage;
  logic                fetch_req;
  logic                cached_variant;
  logic                cache_enable;
  logic                hold_front;
  logic                ma_active;
  logic                ma_fetch_split;
  logic                mult_access;
  logic                mult_busy;
  int                  err_total;
  int                  comparisons;

  mci_interlock uut (
    .clock          (clock),
    .reset_n        (reset_n),
    .ex_stage       (ex_stage),
    .fetch_req      (fetch_req),
    .cached_variant (cached_variant),
    .cache_enable   (cache_enable),
    .hold_front     (hold_front),
    .ma_active      (ma_active),
    .ma_fetch_split (ma_fetch_split),
    .mult_access    (mult_access),
    .mult_busy      (mult_busy)
  );

  always #10 clock = ~clock;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("Mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // Judge this cycle at the falling edge, then present the next request
  task automatic step(input logic h, b, s, input mci_pkg::mci_op_t op, input logic v, f);
    @(negedge clock);
    check("hold_front", hold_front, h);
    check("mult_busy", mult_busy, b);
    check("ma_fetch_split", ma_fetch_split, s);
    ex_stage  = mci_pkg::mci_stage_t'{v, op};
    fetch_req = f;
  endtask : step

  // Request drops to OTHER while refused; ma_q keeps the stretched op stable
  task automatic run_contention(input mci_pkg::mci_op_t op, input logic fet);
    step(0, 0, 0, mci_pkg::MCI_OP_MULW, 1, 0);
    step(0, 0, 0, op, 1, 0);
    check("mult_access", mult_access, 1'b1);
    step(1, 1, 0, mci_pkg::MCI_OP_OTHER, 1, 0);
    check("ma_active", ma_active, 1'b1);
    step(1, 1, 0, mci_pkg::MCI_OP_OTHER, 1, fet);
    step(fet, 0, 0, mci_pkg::MCI_OP_OTHER, 1, fet);
    check("mult_access", mult_access, !fet);
    step(0, 0, fet, mci_pkg::MCI_OP_OTHER, fet, 0);
    step(0, 0, 0, mci_pkg::MCI_OP_OTHER, 0, 0);
  endtask : run_contention

  // Fetch meets the access stage with the multiplier idle: split only
  task automatic run_idle_split(input mci_pkg::mci_op_t op);
    step(0, 0, 0, op, 1, 1);
    step(1, 0, 0, mci_pkg::MCI_OP_OTHER, 1, 1);
    step(0, 0, 1, mci_pkg::MCI_OP_OTHER, 1, 0);
    step(0, 0, 0, mci_pkg::MCI_OP_OTHER, 0, 0);
  endtask : run_idle_split

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic scenario_register_moves;
    for (int f = 0; f < 2; f++) begin
      run_contention(mci_pkg::MCI_OP_STS_REG, f[0]);
      run_contention(mci_pkg::MCI_OP_LDS_REG, f[0]);
    end
    run_idle_split(mci_pkg::MCI_OP_STS_REG);
    run_idle_split(mci_pkg::MCI_OP_LDS_REG);
  endtask : scenario_register_moves

  // Uncached variant stalls even with the cache on
  task automatic scenario_store_uncached;
    cached_variant = 1'b0;
    cache_enable   = 1'b1;
    run_contention(mci_pkg::MCI_OP_STS_MEM, 1'b1);
    run_contention(mci_pkg::MCI_OP_STS_MEM, 1'b0);
  endtask : scenario_store_uncached

  task automatic scenario_store_cached;
    cached_variant = 1'b1;
    step(0, 0, 0, mci_pkg::MCI_OP_MULW, 1, 0);
    step(0, 0, 0, mci_pkg::MCI_OP_STS_MEM, 1, 0);
    step(0, 1, 0, mci_pkg::MCI_OP_OTHER, 0, 0);
    step(0, 1, 0, mci_pkg::MCI_OP_OTHER, 0, 0);
    step(0, 0, 0, mci_pkg::MCI_OP_OTHER, 0, 0);
    cache_enable = 1'b0;
    run_contention(mci_pkg::MCI_OP_STS_MEM, 1'b0);
    cached_variant = 1'b0;
  endtask : scenario_store_cached

  task automatic scenario_double_multiply;
    step(0, 0, 0, mci_pkg::MCI_OP_MULW, 1, 0);
    step(0, 0, 0, mci_pkg::MCI_OP_DMUL, 1, 0);
    step(0, 1, 0, mci_pkg::MCI_OP_OTHER, 0, 0);
    step(0, 1, 0, mci_pkg::MCI_OP_OTHER, 0, 0);
  endtask : scenario_double_multiply

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clock          = 1'b0;
    reset_n        = 1'b0;
    ex_stage       = mci_pkg::mci_stage_t'{1'b0, mci_pkg::MCI_OP_OTHER};
    fetch_req      = 1'b0;
    cached_variant = 1'b0;
    cache_enable   = 1'b0;
    err_total      = 0;
    comparisons    = 0;
    repeat (10) @(negedge clock);
    check("ma_active", ma_active, 1'b0);
    reset_n = 1'b1;
    scenario_register_moves();
    scenario_store_uncached();
    scenario_store_cached();
    scenario_double_multiply();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
